// file: bench/remote_serial_model.sv
`timescale 1ns/1ns
module remote_serial_model #(
  parameter int BIT_CYC = 208
) (
  // clock
  input wire clk,
  // device side line
  input wire tx_line,
  input wire tx_sel,
  // toward the device, idles high
  output logic rx_line
);
  logic [8:0] got = 9'h000;
  logic stop_ok = 1'b0;
  int cnt = 0;
  initial rx_line = 1'b1;
  // start, nine bits lsb first, stop
  task automatic send(input logic [8:0] d, input logic glitch);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      for (int k = 0; k < BIT_CYC; k++) begin
        @(posedge clk);
        // spike covering one of three samples
        rx_line <= f[i] ^ (glitch && i == 3 && k >= 117 && k < 143);
      end
    end
  endtask
  always @(posedge clk) begin
    if (cnt == 0) begin
      // line only trusted while select is high; the port holds it high otherwise
      if (tx_sel && !tx_line) cnt <= 1;
    end else begin
      cnt <= cnt + 1;
      if (cnt % BIT_CYC == BIT_CYC / 2) begin
        if (cnt / BIT_CYC == 10) begin
          stop_ok <= tx_line;
          cnt <= 0;
        end else got <= {tx_line, got[8:1]};
      end
    end
  end
endmodule

// file: bench/serial_port_checker_assertions.sv
`timescale 1ns/1ns
`include "serial_port_regs.vh"
module serial_port_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // register bus
  input wire [`ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata_ff,
  input wire waitrequest_ff,
  // serial line and requests
  input wire serial_in_pin,
  input wire serial_out_pin_ff,
  input wire tx_output_select_ff,
  input wire tx_irq_ff,
  input wire rx_irq_ff
);
  wire wr_done = write && !waitrequest_ff && byteenable[0];
  wire go = wr_done && address == 10'h358;
  reg [12:0] cnt_ff;
  reg fast_ff;
  // frame length only judged at the fastest code, where it stays short
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 13'h0000;
      fast_ff <= 1'b0;
    end else begin
      cnt_ff <= go ? 13'h0000 : cnt_ff + 13'h0001;
      if (wr_done && address == 10'h35c) begin
        fast_ff <= writedata[3:1] == 3'h6;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_WAIT_ONE: assert property (
    (read || write) && waitrequest_ff |=> !waitrequest_ff) else $error("bus not answered");
  AST_WAIT_PULSE: assert property (
    !waitrequest_ff |=> waitrequest_ff) else $error("answer longer than one cycle");
  AST_READ_HI_ZERO: assert property (
    read && !waitrequest_ff |-> readdata_ff[31:8] == 24'h000000) else $error("read upper bits");
  AST_UNMAPPED: assert property (
    read && !waitrequest_ff && address < 10'h358 |-> readdata_ff == 32'h00000000)
    else $error("unmapped read not zero");
  AST_START_LOW: assert property (
    go |=> tx_output_select_ff && !serial_out_pin_ff) else $error("no start bit");
  AST_START_HOLD: assert property (
    $rose(tx_output_select_ff) |-> !serial_out_pin_ff [*8]) else $error("start bit short");
  AST_IDLE_HIGH: assert property (
    !tx_output_select_ff |-> serial_out_pin_ff) else $error("idle line low");
  AST_STOP_HIGH: assert property (
    $fell(tx_output_select_ff) |-> $past(serial_out_pin_ff)) else $error("stop bit low");
  AST_FRAME_LEN: assert property (
    $fell(tx_output_select_ff) && fast_ff |-> cnt_ff > 13'h08ec && cnt_ff < 13'h08f4)
    else $error("frame length wrong");
  cover property ($fell(tx_output_select_ff));
  cover property ($rose(tx_irq_ff));
  cover property ($rose(rx_irq_ff));
endmodule
bind half_duplex_async_serial_port serial_port_checker chk_u (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata_ff(readdata_ff), .waitrequest_ff(waitrequest_ff),
  .serial_in_pin(serial_in_pin), .serial_out_pin_ff(serial_out_pin_ff),
  .tx_output_select_ff(tx_output_select_ff), .tx_irq_ff(tx_irq_ff), .rx_irq_ff(rx_irq_ff));

// file: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata_ff;
  logic waitrequest_ff, serial_in_pin, serial_out_pin_ff;
  logic tx_output_select_ff, tx_irq_ff, rx_irq_ff;
  logic [7:0] q;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  localparam logic [9:0] DR = 10'h358;
  localparam logic [9:0] CR = 10'h35c;
  always #25 clk = ~clk;
  half_duplex_async_serial_port dut_u (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata_ff(readdata_ff), .waitrequest_ff(waitrequest_ff),
    .serial_in_pin(serial_in_pin), .serial_out_pin_ff(serial_out_pin_ff),
    .tx_output_select_ff(tx_output_select_ff), .tx_irq_ff(tx_irq_ff), .rx_irq_ff(rx_irq_ff));
  remote_serial_model p_u (.clk(clk), .tx_line(serial_out_pin_ff),
    .tx_sel(tx_output_select_ff), .rx_line(serial_in_pin));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int k;
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, d};
    byteenable <= be;
    write <= w;
    read <= !w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest_ff !== 1'b0 && k < 50);
    chk("waitrequest", 32'h0, {31'h0, waitrequest_ff});
    q = readdata_ff[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [9:0] a);
    bus(1'b0, a, 8'h00, 4'h1);
  endtask
  // line drop lands at least one edge after the write took effect
  task automatic wait_fall;
    repeat (2) @(posedge clk);
    n = 0;
    while (tx_output_select_ff !== 1'b0 && n < 6000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic wait_rx;
    n = 0;
    while (rx_irq_ff !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("rx irq", 32'h1, {31'h0, rx_irq_ff});
  endtask
  task automatic t_reset;
    rd(CR);
    chk("ctrl reset", 32'h0, q);
    rd(DR);
    chk("data reset", 32'h0, q);
    chk("select idle", 32'h0, {31'h0, tx_output_select_ff});
  endtask
  task automatic t_refuse;
    wr(10'h000, 8'hff);
    rd(10'h000);
    chk("unmapped", 32'h0, q);
    bus(1'b1, CR, 8'h5f, 4'h0);
    rd(CR);
    chk("masked write", 32'h0, q);
  endtask
  task automatic t_flags;
    logic [7:0] cv[6];
    cv = '{8'h4c, 8'h5c, 8'h1c, 8'h8c, 8'hac, 8'h2c};
    for (int i = 0; i < 6; i++) begin
      wr(CR, cv[i]);
      repeat (3) @(posedge clk);
      chk("tx irq", {31'h0, cv[i][6] & cv[i][4]}, {31'h0, tx_irq_ff});
      chk("rx irq", {31'h0, cv[i][7] & cv[i][5]}, {31'h0, rx_irq_ff});
    end
  endtask
  task automatic t_tx;
    wr(CR, 8'h5d);
    wr(DR, 8'ha5);
    rd(CR);
    chk("tx empty cleared", 32'h1d, q);
    wait_fall();
    repeat (2) @(posedge clk);
    chk("tx frame", 32'h1a5, {23'h0, p_u.got});
    chk("stop bit", 32'h1, {31'h0, p_u.stop_ok});
    rd(CR);
    chk("tx empty set", 32'h5d, q);
    chk("tx irq", 32'h1, {31'h0, tx_irq_ff});
    wr(DR, 8'h3c);
    wait_fall();
    chk("ninth kept", 32'h13c, {23'h0, p_u.got});
  endtask
  task automatic t_rx;
    wr(CR, 8'h2c);
    p_u.send({^8'h5b, 8'h5b}, 1'b1);
    wait_rx();
    rd(DR);
    chk("rx data", 32'h5b, q);
    rd(CR);
    chk("rx ctrl", 32'had, q);
    wr(CR, 8'h2d);
    p_u.send(9'h080, 1'b0);
    wait_rx();
    rd(CR);
    chk("ninth overwritten", 32'hac, q);
    rd(DR);
    chk("second data", 32'h80, q);
  endtask
  task automatic t_abort;
    wr(CR, 8'h0c);
    fork
      p_u.send(9'h0ff, 1'b0);
      begin
        repeat (700) @(posedge clk);
        wr(DR, 8'h55);
      end
    join
    wait_fall();
    repeat (300) @(posedge clk);
    rd(CR);
    chk("rx abandoned", 32'h4c, q);
    chk("tx won", 32'h055, {23'h0, p_u.got});
  endtask
  task automatic t_reset_mid;
    wr(CR, 8'h0c);
    wr(DR, 8'haa);
    repeat (100) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("select after reset", 32'h0, {31'h0, tx_output_select_ff});
    chk("line after reset", 32'h1, {31'h0, serial_out_pin_ff});
    rst <= 1'b0;
    rd(CR);
    chk("ctrl after reset", 32'h0, q);
  endtask
  task automatic t_baud;
    int dv[7];
    int e;
    dv = '{6656, 3328, 1664, 832, 416, 256, 208};
    // slow codes time only the start bit to keep the run short; the next data register write restarts
    for (int c = 0; c < 7; c++) begin
      wr(CR, {4'h0, c[2:0], 1'b0});
      wr(DR, (c < 4) ? 8'hff : 8'h00);
      if (c < 4) begin
        @(posedge clk);
        n = 0;
        while (serial_out_pin_ff !== 1'b1 && n < 7000) begin
          @(posedge clk);
          n++;
        end
        e = dv[c];
      end else begin
        wait_fall();
        e = dv[c] * 11;
      end
      samples_checked++;
      if (n < e - 4 || n > e + 4) begin
        failures++;
        $display("[ERR] bit cycles expected %0d seen %0d", e, n);
      end
    end
    wr(CR, 8'h0e);
    wr(DR, 8'hff);
    repeat (300) @(posedge clk);
    chk("stalled", 32'h1, {31'h0, tx_output_select_ff & ~serial_out_pin_ff});
    wr(CR, 8'h0c);
    wr(DR, 8'h00);
    wait_fall();
    chk("frame after stall", 32'h0, {31'h0, tx_output_select_ff});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_refuse();
    t_flags();
    t_tx();
    t_rx();
    t_abort();
    t_reset_mid();
    t_baud();
    conclude();
  end
endmodule

// file: logic/baud_tick.v
`timescale 1ns/1ns
`include "serial_port_regs.vh"

module baud_tick #(
  parameter CNT_W = 10
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire [2:0] baud_select,
  input wire restart,
  // eight ticks per bit
  output reg tick_ff
);

  reg [CNT_W-1:0] cnt_ff;
  reg [12:0] bit_div;
  wire [CNT_W-1:0] reload;
  wire [CNT_W-1:0] last;
  wire valid;

  // (R20) per-bit division by baud code
  always @* begin
    case (baud_select)
      3'h0: bit_div = `BIT_DIV_0;
      3'h1: bit_div = `BIT_DIV_1;
      3'h2: bit_div = `BIT_DIV_2;
      3'h3: bit_div = `BIT_DIV_3;
      3'h4: bit_div = `BIT_DIV_4;
      3'h5: bit_div = `BIT_DIV_5;
      3'h6: bit_div = `BIT_DIV_6;
      default: bit_div = `BIT_DIV_NONE;
    endcase
  end

  assign reload = bit_div[`STATE_SHIFT +: CNT_W];
  assign last = reload - {{(CNT_W-1){1'b0}}, 1'b1};
  // the reserved code yields no tick at all, so the link simply stalls
  assign valid = |reload;

  // (R26) restartable tick counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= {CNT_W{1'b0}};
      tick_ff <= 1'b0;
    end else if (restart || !valid) begin
      cnt_ff <= {CNT_W{1'b0}};
      tick_ff <= 1'b0;
    end else if (cnt_ff >= last) begin
      // >= so a baud change to a faster rate cannot overrun the count
      cnt_ff <= {CNT_W{1'b0}};
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      tick_ff <= 1'b0;
    end
  end

endmodule

// file: logic/half_duplex_async_serial_port.v
// Behaviour
// (R01) divider makes a tick at eight times the bit rate
// (R02) three samples per bit, two-of-three majority decides the value
// (R03) frame is start bit, nine data bits, stop bit, framing by hardware
// (R04) software computes any parity itself; hardware neither makes nor checks it
// (R05) stored ninth bit persists until rewritten or overwritten by reception
// (R06) data register write loads the shifter and starts sending at once
// (R07) output select asserted, low start bit, eight bits lsb first, ninth bit
// (R08) stop bit high for one bit time, then output select drops
// (R09) end of transmission sets tx empty and requests interrupt if enabled
// (R10) tx empty cleared by writing zero or by writing the data register
// (R11) writing one to tx empty sets it, giving a software interrupt
// (R12) receiver watches for a falling edge whenever no transmission runs
// (R13) after the edge, skip one bit time of eight states, then shift data
// (R14) received ninth bit overwrites the ninth bit control field
// (R15) after nine bits wait one stop bit, then move character to buffer
// (R16) rx ready set on transfer to buffer, interrupt if enabled
// (R17) starting a transmission abandons any reception in progress
// (R18) data register read gives receive buffer, write goes to transmit shifter
// (R19) software avoids read-modify-write on the data register
// (R20) baud codes divide by 6656 down to 208 per bit; code 111 reserved
// (R21) each interrupt gated by its own enable, flags name the source
// (R22) software holds the port bit high for idle level when not sending
// (R23) control register layout fixed; baud select changes act at once
// (R24) rx ready cleared by writing zero; writing one sets it
// (R25) reset returns both directions to idle with output select low
// (R26) tick counts one eighth of the divisor and restarts per character
`timescale 1ns/1ns
`include "serial_port_regs.vh"

module half_duplex_async_serial_port #(
  parameter TICK_CNT_W = 10
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // avalon-mm slave
  input wire [`ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata_ff,
  output reg waitrequest_ff,
  // serial line
  input wire serial_in_pin,
  output reg serial_out_pin_ff,
  output reg tx_output_select_ff,
  // interrupt requests
  output reg tx_irq_ff,
  output reg rx_irq_ff
);

  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  // control register fields
  reg rx_ready_flag_ff;
  reg tx_empty_flag_ff;
  reg rx_irq_enable_ff;
  reg tx_irq_enable_ff;
  reg [2:0] baud_select_ff;
  reg ninth_bit_ff;
  reg nxt_rx_ready_flag;
  reg nxt_tx_empty_flag;
  reg nxt_ninth_bit;

  // receive side
  reg [7:0] rx_buffer_ff;
  reg [8:0] rx_shift_ff;
  reg [1:0] rx_state_ff;
  reg [1:0] nxt_rx_state;
  reg [3:0] rx_bits_ff;
  reg [2:0] votes_ff;
  reg rx_prev_ff;

  // transmit side
  reg [10:0] tx_frame_ff;
  reg [3:0] tx_bits_ff;
  reg tx_active_ff;

  // shared bit timing
  reg [2:0] phase_ff;
  reg [7:0] rd_byte;

  wire tick;
  wire rx_level;
  wire access;
  wire sel_data;
  wire sel_ctrl;
  wire wr_data;
  wire wr_ctrl;
  wire bit_end;
  wire rx_fall;
  wire rx_begin;
  wire rx_bit;
  wire rx_done;
  wire tx_done;
  wire tick_restart;

  assign access = (read || write) && !waitrequest_ff;
  assign sel_data = (address == {`DATA_IDX, 2'b00});
  assign sel_ctrl = (address == {`CTRL_IDX, 2'b00});
  assign wr_data = access && write && sel_data && byteenable[0];
  assign wr_ctrl = access && write && sel_ctrl && byteenable[0];

  // (R01) eight ticks per bit from the selected divisor
  assign bit_end = tick && (phase_ff == `PHASE_LAST);
  // (R02) majority of the three votes
  assign rx_bit = (votes_ff[0] & votes_ff[1]) | (votes_ff[1] & votes_ff[2]) |
                  (votes_ff[0] & votes_ff[2]);
  assign rx_fall = rx_prev_ff && !rx_level;
  // (R12) look for a start edge only while not sending
  assign rx_begin = (rx_state_ff == RX_IDLE) && !tx_active_ff && rx_fall && !wr_data;
  // (R15) character complete after the stop bit time
  assign rx_done = (rx_state_ff == RX_STOP) && bit_end && !wr_data;
  assign tx_done = tx_active_ff && bit_end && (tx_bits_ff == `FRAME_BITS - `BITS_ONE) &&
                   !wr_data;
  // (R26) each new character restarts the tick and the phase
  assign tick_restart = wr_data || rx_begin;

  baud_tick #(
    .CNT_W(TICK_CNT_W)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .baud_select(baud_select_ff),
    .restart(tick_restart),
    .tick_ff(tick)
  );

  rx_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pin(serial_in_pin),
    .level_ff(rx_level)
  );

  // (R18) read side of the data address is the receive buffer
  always @* begin
    rd_byte = `RST_BYTE;
    if (sel_data) begin
      rd_byte = rx_buffer_ff;
    end else if (sel_ctrl) begin
      // (R23) control register layout
      rd_byte[`CR_RX_READY] = rx_ready_flag_ff;
      rd_byte[`CR_TX_EMPTY] = tx_empty_flag_ff;
      rd_byte[`CR_RX_IRQ_EN] = rx_irq_enable_ff;
      rd_byte[`CR_TX_IRQ_EN] = tx_irq_enable_ff;
      rd_byte[`CR_BAUD_HI:`CR_BAUD_LO] = baud_select_ff;
      rd_byte[`CR_NINTH] = ninth_bit_ff;
    end
  end

  // one wait cycle per access; read data captured while waitrequest is high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest_ff <= 1'b1;
      readdata_ff <= `RST_WORD;
    end else if ((read || write) && waitrequest_ff) begin
      waitrequest_ff <= 1'b0;
      if (read) begin
        readdata_ff <= {`RST_PAD, rd_byte};
      end
    end else begin
      waitrequest_ff <= 1'b1;
    end
  end

  // control fields written by software; baud takes effect immediately
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_irq_enable_ff <= 1'b0;
      tx_irq_enable_ff <= 1'b0;
      baud_select_ff <= `RST_BAUD;
    end else if (wr_ctrl) begin
      // (R23) enables and baud select from the control write
      rx_irq_enable_ff <= writedata[`CR_RX_IRQ_EN];
      tx_irq_enable_ff <= writedata[`CR_TX_IRQ_EN];
      baud_select_ff <= writedata[`CR_BAUD_HI:`CR_BAUD_LO];
    end
  end

  // flags: hardware events are applied last so they win over a clear
  always @* begin
    nxt_tx_empty_flag = tx_empty_flag_ff;
    nxt_rx_ready_flag = rx_ready_flag_ff;
    nxt_ninth_bit = ninth_bit_ff;
    if (wr_ctrl) begin
      // (R11) software may set or clear tx empty
      nxt_tx_empty_flag = writedata[`CR_TX_EMPTY];
      // (R24) software may set or clear rx ready
      nxt_rx_ready_flag = writedata[`CR_RX_READY];
      // (R05) ninth bit only changes on a write or a reception
      nxt_ninth_bit = writedata[`CR_NINTH];
    end
    // (R10) a data write clears tx empty
    if (wr_data) begin
      nxt_tx_empty_flag = 1'b0;
    end
    // (R09) end of transmission sets tx empty
    if (tx_done) begin
      nxt_tx_empty_flag = 1'b1;
    end
    if (rx_done) begin
      // (R16) transfer to buffer sets rx ready
      nxt_rx_ready_flag = 1'b1;
      // (R14) received ninth bit replaces the stored one
      nxt_ninth_bit = rx_shift_ff[8];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_empty_flag_ff <= 1'b0;
      rx_ready_flag_ff <= 1'b0;
      ninth_bit_ff <= 1'b0;
    end else begin
      tx_empty_flag_ff <= nxt_tx_empty_flag;
      rx_ready_flag_ff <= nxt_rx_ready_flag;
      ninth_bit_ff <= nxt_ninth_bit;
    end
  end

  // (R21) each request gated by its own enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      tx_irq_ff <= tx_empty_flag_ff && tx_irq_enable_ff;
      rx_irq_ff <= rx_ready_flag_ff && rx_irq_enable_ff;
    end
  end

  // phase within the bit, eight states
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_ff <= `PHASE_ZERO;
    end else if (tick_restart) begin
      phase_ff <= `PHASE_ZERO;
    end else if (tick) begin
      phase_ff <= phase_ff + `PHASE_ONE;
    end
  end

  // transmitter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // (R25) idle, pin handed back to the port logic
      tx_active_ff <= 1'b0;
      tx_output_select_ff <= 1'b0;
      serial_out_pin_ff <= 1'b1;
      tx_frame_ff <= {11{1'b1}};
      tx_bits_ff <= `BITS_ZERO;
    end else if (wr_data) begin
      // (R06) load shifter and start at once; a write mid-frame restarts it
      // (R03) stop, ninth bit, data, start framed by hardware
      tx_frame_ff <= {1'b1, ninth_bit_ff, writedata[7:0], 1'b0};
      tx_bits_ff <= `BITS_ZERO;
      tx_active_ff <= 1'b1;
      // (R07) select the transmitter and drive the start bit
      tx_output_select_ff <= 1'b1;
      serial_out_pin_ff <= 1'b0;
    end else if (tx_done) begin
      // (R08) stop bit done, release the pin
      tx_active_ff <= 1'b0;
      tx_output_select_ff <= 1'b0;
      serial_out_pin_ff <= 1'b1;
    end else if (tx_active_ff && bit_end) begin
      // (R07) lsb first, ninth bit, then the high stop bit
      tx_frame_ff <= {1'b1, tx_frame_ff[10:1]};
      serial_out_pin_ff <= tx_frame_ff[1];
      tx_bits_ff <= tx_bits_ff + `BITS_ONE;
    end
  end

  // receiver state machine
  always @* begin
    nxt_rx_state = rx_state_ff;
    case (rx_state_ff)
      RX_IDLE: begin
        if (rx_begin) begin
          nxt_rx_state = RX_START;
        end
      end
      RX_START: begin
        // (R13) skip eight states of start bit
        if (bit_end) begin
          nxt_rx_state = RX_DATA;
        end
      end
      RX_DATA: begin
        if (bit_end && (rx_bits_ff == `DATA_BITS - `BITS_ONE)) begin
          nxt_rx_state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (bit_end) begin
          nxt_rx_state = RX_IDLE;
        end
      end
      default: begin
        nxt_rx_state = RX_IDLE;
      end
    endcase
    // (R17) a transmission start abandons reception
    if (wr_data) begin
      nxt_rx_state = RX_IDLE;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_ff <= RX_IDLE;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_prev_ff <= rx_level;
    end
  end

  // (R02) three timed samples near the middle of the bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      votes_ff <= 3'h7;
    end else if (tick) begin
      if (phase_ff == `SAMPLE_A) begin
        votes_ff[0] <= rx_level;
      end
      if (phase_ff == `SAMPLE_B) begin
        votes_ff[1] <= rx_level;
      end
      if (phase_ff == `SAMPLE_C) begin
        votes_ff[2] <= rx_level;
      end
    end
  end

  // data shifter and bit count, lsb arrives first
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_shift_ff <= 9'h000;
      rx_bits_ff <= `BITS_ZERO;
    end else if (rx_begin) begin
      rx_bits_ff <= `BITS_ZERO;
    end else if ((rx_state_ff == RX_DATA) && bit_end) begin
      rx_shift_ff <= {rx_bit, rx_shift_ff[8:1]};
      rx_bits_ff <= rx_bits_ff + `BITS_ONE;
    end
  end

  // receive buffer frees the shifter for the next character
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buffer_ff <= `RST_BYTE;
    end else if (rx_done) begin
      // (R15) move the character to the buffer
      rx_buffer_ff <= rx_shift_ff[7:0];
    end
  end

endmodule

// file: logic/rx_sync.v
`timescale 1ns/1ns

module rx_sync (
  // clock and reset
  input wire clk,
  input wire rst,
  // pin side
  input wire pin,
  // filtered level
  output reg level_ff
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // idle line is high, so everything resets high to avoid a false start edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      level_ff <= 1'b1;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

endmodule

// file: logic/serial_port_regs.vh
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

// register indices; the byte address is four times the index
`define ADDR_W 10
`define DATA_IDX 8'hd6
`define CTRL_IDX 8'hd7

// control register fields
`define CR_RX_READY 7
`define CR_TX_EMPTY 6
`define CR_RX_IRQ_EN 5
`define CR_TX_IRQ_EN 4
`define CR_BAUD_HI 3
`define CR_BAUD_LO 1
`define CR_NINTH 0

// reset values
`define RST_BYTE 8'h00
`define RST_BAUD 3'h0
`define RST_PAD 24'h000000
`define RST_WORD 32'h00000000

// internal clock division per bit, by baud select code
`define BIT_DIV_0 13'h1a00
`define BIT_DIV_1 13'h0d00
`define BIT_DIV_2 13'h0680
`define BIT_DIV_3 13'h0340
`define BIT_DIV_4 13'h01a0
`define BIT_DIV_5 13'h0100
`define BIT_DIV_6 13'h00d0
`define BIT_DIV_NONE 13'h0000

// eight sample states per bit: tick period is the bit division shifted right by 3
`define STATE_SHIFT 3
`define PHASE_ZERO 3'h0
`define PHASE_ONE 3'h1
`define PHASE_LAST 3'h7
`define SAMPLE_A 3'h3
`define SAMPLE_B 3'h4
`define SAMPLE_C 3'h5

// character framing: start, nine data, stop
`define FRAME_BITS 4'hb
`define DATA_BITS 4'h9
`define BITS_ZERO 4'h0
`define BITS_ONE 4'h1

`endif
